/* File: inc/eewc_pkg.sv */
/*
 * Shared constants and types of the EEPROM write-command logic.
 * Assumes a 40 MHz system clock; the link side runs on its own clock.
 */
package eewc_pkg;

	// ****************************************************************
	// Address byte layout
	// ****************************************************************
	localparam logic [3:0] TYPE_MAIN = 4'ha;
	localparam logic [3:0] TYPE_AUX = 4'hb;
	localparam int DEV_TYPE_LSB = 4;
	localparam int DEV_CS_LSB = 2;
	localparam int DEV_A8_BIT = 1;
	localparam int DEV_RW_BIT = 0;

	// ****************************************************************
	// Word address select field for the auxiliary type code
	// ****************************************************************
	localparam int SEL_LSB = 6;
	localparam logic [1:0] SEL_IDENT = 2'h0;
	localparam logic [1:0] SEL_LOCK = 2'h1;
	localparam logic [1:0] SEL_UID = 2'h2;
	localparam logic [1:0] SEL_SOFT_LOCK = 2'h3;

	// ****************************************************************
	// Data byte fields and sizes
	// ****************************************************************
	localparam int LOCK_DATA_BIT = 1;
	localparam int DATA_BIT_ZERO = 0;
	localparam int PAGE_BYTES = 16;
	localparam int MAIN_BYTES = 512;
	localparam int ADDR_W = 9;
	localparam int IDX_W = 4;
	localparam int CNT_W = 5;

	// ****************************************************************
	// Reset values of the non-volatile bits
	// ****************************************************************
	localparam logic SOFT_LOCK_RESET = 1'b0;
	localparam logic LOCK_RESET = 1'b0;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int WRITE_CYCLE_TIME_NS = 3000000;
	localparam int SYS_CLK_PERIOD_NS = 25;
	// Longest time rounds down
	localparam int WRITE_CYCLES = WRITE_CYCLE_TIME_NS / SYS_CLK_PERIOD_NS;

	// ****************************************************************
	// Write operation kinds
	// ****************************************************************
	typedef enum logic [4:0] {
		OP_NONE = 5'h01,
		OP_MAIN = 5'h02,
		OP_IDENT = 5'h04,
		OP_LOCK = 5'h08,
		OP_SOFT_LOCK = 5'h10
	} eewc_op_t;

endpackage

/* File: src/eewc_commit.sv */
/*
 * Commit engine on the system clock: runs the self-timed write cycle,
 * holds the arrays, the lock flag and the soft write lock.
 * Assumes the request fields stay stable from the request toggle until
 * the done toggle returns.
 */
`timescale 1ns/1ps
module eewc_commit #(
	parameter int WRITE_CYCLES = eewc_pkg::WRITE_CYCLES
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic i_req_tgl,
	input wire eewc_pkg::eewc_op_t i_op,
	input wire logic [eewc_pkg::ADDR_W-1:0] i_base,
	input wire logic [eewc_pkg::PAGE_BYTES-1:0][7:0] i_data,
	input wire logic [eewc_pkg::PAGE_BYTES-1:0] i_vld,
	input wire logic [eewc_pkg::CNT_W-1:0] i_count,
	output logic o_done_tgl,
	output logic o_busy,
	output logic o_soft_write_lock_bit,
	output logic o_locked
);
	localparam int TW = $clog2(WRITE_CYCLES + 1);

	typedef enum logic [2:0] {
		C_IDLE = 3'h1,
		C_PROG = 3'h2,
		C_WAIT = 3'h4
	} eewc_cst_t;

	typedef struct packed {
		logic req_s1;
		logic req_s2;
		logic req_s3;
		eewc_cst_t st;
		logic [TW-1:0] timer;
		logic done_tgl;
		logic soft_write_lock_bit;
		logic locked;
	} eewc_cstate_t;

	eewc_cstate_t r;
	eewc_cstate_t next_r;
	logic [7:0] main_mem [eewc_pkg::MAIN_BYTES];
	logic [7:0] ident_mem [eewc_pkg::PAGE_BYTES];
	logic [7:0] sel_byte;

	assign sel_byte = i_data[i_base[eewc_pkg::IDX_W-1:0]];

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	// Toggle crossing, then program, then hold busy for the timer
	always_comb begin
		next_r = r;
		next_r.req_s1 = i_req_tgl;
		next_r.req_s2 = r.req_s1;
		next_r.req_s3 = r.req_s2;
		unique case (r.st)
			C_IDLE: begin
				if (r.req_s2 ^ r.req_s3) begin
					next_r.st = C_PROG;
					next_r.timer = TW'(WRITE_CYCLES - 1);
				end
			end
			C_PROG: begin
				next_r.st = C_WAIT;
				next_r.timer = r.timer - 1'b1;
				// Soft lock may go either way, protection pin not consulted
				if (i_op == eewc_pkg::OP_SOFT_LOCK && i_count == 5'h01) begin
					next_r.soft_write_lock_bit = sel_byte[eewc_pkg::DATA_BIT_ZERO];
				end
				if (i_op == eewc_pkg::OP_LOCK && i_count == 5'h01 && sel_byte[eewc_pkg::LOCK_DATA_BIT]) begin
					next_r.locked = 1'b1;
				end
			end
			C_WAIT: begin
				if (r.timer == '0) begin
					next_r.st = C_IDLE;
					next_r.done_tgl = ~r.done_tgl;
				end else begin
					next_r.timer = r.timer - 1'b1;
				end
			end
			default: next_r.st = C_IDLE;
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			r <= '{req_s1: 1'b0, req_s2: 1'b0, req_s3: 1'b0, st: C_IDLE, timer: '0,
				done_tgl: 1'b0, soft_write_lock_bit: eewc_pkg::SOFT_LOCK_RESET, locked: eewc_pkg::LOCK_RESET};
		end else begin
			r <= next_r;
		end
	end

	// ****************************************************************
	// Arrays
	// ****************************************************************
	// Whole buffered page lands in one cycle
	always_ff @(posedge i_sys_clk) begin
		if (r.st == C_PROG) begin
			for (int i = 0; i < eewc_pkg::PAGE_BYTES; i++) begin
				if (i_vld[i] && i_op == eewc_pkg::OP_MAIN) begin
					main_mem[{i_base[8:4], 4'(i)}] <= i_data[i];
				end
				if (i_vld[i] && i_op == eewc_pkg::OP_IDENT) begin
					ident_mem[i] <= i_data[i];
				end
			end
		end
	end

	assign o_done_tgl = r.done_tgl;
	assign o_busy = (r.st != C_IDLE);
	assign o_soft_write_lock_bit = r.soft_write_lock_bit;
	assign o_locked = r.locked;
endmodule

/* File: src/eewc_top.sv */
/*
 * Two-wire target logic for write-type commands of a serial EEPROM:
 * address decode, acknowledge, page buffering and commit handshake.
 * Assumes a free-running oversampling link clock, much faster than
 * the serial clock, and an open-drain data wire resolved outside.
 */
`timescale 1ns/1ps

module eewc_top #(
	parameter int WRITE_CYCLES = eewc_pkg::WRITE_CYCLES
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic i_link_clk,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda,
	output logic o_sda_oe_b,
	input wire logic i_write_protect_pin,
	input wire logic [1:0] i_chip_select_bits,
	output logic o_busy,
	output logic o_soft_write_lock_bit,
	output logic o_ident_locked
);
	// Link states; L_SKIP sits out refused and read transfers
	typedef enum logic [5:0] {
		L_IDLE = 6'h01,
		L_DEV = 6'h02,
		L_WORD = 6'h04,
		L_DATA = 6'h08,
		L_ACK = 6'h10,
		L_SKIP = 6'h20
	} eewc_lst_t;

	// Whole link-side state, registered as one word
	typedef struct packed {
		logic scl_s1;
		logic scl_s2;
		logic scl_s3;
		logic sda_s1;
		logic sda_s2;
		logic sda_s3;
		logic wp_s1;
		logic wp_s2;
		logic [1:0] cs_s1;
		logic [1:0] cs_s2;
		logic soft_lock_s1;
		logic soft_lock_s2;
		logic lck_s1;
		logic lck_s2;
		logic done_s1;
		logic done_s2;
		eewc_lst_t st;
		eewc_lst_t after;
		logic [3:0] bitcnt;
		logic [7:0] sh;
		logic want_ack;
		logic drive;
		logic [eewc_pkg::ADDR_W-1:0] addr;
		eewc_pkg::eewc_op_t op;
		logic [eewc_pkg::PAGE_BYTES-1:0][7:0] pbuf;
		logic [eewc_pkg::PAGE_BYTES-1:0] vld;
		logic [eewc_pkg::CNT_W-1:0] nbytes;
		logic req_tgl;
	} eewc_lstate_t;

	eewc_lstate_t r;
	eewc_lstate_t next_r;
	// Engine status; all but busy crosses back through two flip-flops
	logic done_tgl;
	logic busy;
	logic soft_write_lock_bit;
	logic locked;
	logic addr_ack;
	logic data_ack;
	logic pending;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	logic last_bit;
	logic prot;
	logic [7:0] byte_in;
	logic [eewc_pkg::IDX_W-1:0] idx;

	// ****************************************************************
	// Decode helpers
	// ****************************************************************
	// Address byte is ours: valid type code and matching straps
	function automatic logic addr_match(input logic [7:0] b, input logic [1:0] cs);
		logic type_ok;
		type_ok = (b[7:4] == eewc_pkg::TYPE_MAIN) || (b[7:4] == eewc_pkg::TYPE_AUX);
		addr_match = type_ok && (b[3:2] == cs);
	endfunction

	// Acknowledge decision for a data byte of each operation kind
	function automatic logic data_ok(input eewc_pkg::eewc_op_t op, input logic p, input logic lk);
		unique case (op)
			eewc_pkg::OP_MAIN: data_ok = !p;
			eewc_pkg::OP_IDENT: data_ok = !p && !lk;
			eewc_pkg::OP_LOCK: data_ok = !p && !lk;
			// Soft lock updates are taken even when protected
			eewc_pkg::OP_SOFT_LOCK: data_ok = 1'b1;
			default: data_ok = 1'b0;
		endcase
	endfunction

	// ****************************************************************
	// Link condition detection
	// ****************************************************************
	// All taps sit behind the first synchroniser stage
	assign scl_rise = r.scl_s2 & ~r.scl_s3;
	assign scl_fall = ~r.scl_s2 & r.scl_s3;
	assign start_seen = r.scl_s2 & r.scl_s3 & ~r.sda_s2 & r.sda_s3;
	assign stop_seen = r.scl_s2 & r.scl_s3 & r.sda_s2 & ~r.sda_s3;
	// Byte as it will stand after this rising edge
	assign byte_in = {r.sh[6:0], r.sda_s2};
	assign last_bit = scl_rise && (r.bitcnt == 4'h7);
	// Either protection source blocks both areas alike
	assign prot = r.wp_s2 | r.soft_lock_s2;
	assign idx = r.addr[eewc_pkg::IDX_W-1:0];
	// Busy from the commit until the done toggle returns
	assign pending = r.req_tgl ^ r.done_s2;
	// Address byte is ours and the engine is idle
	assign addr_ack = addr_match(byte_in, r.cs_s2) && !pending;
	// Data byte acceptance for the byte in flight
	assign data_ack = data_ok(r.op, prot, r.lck_s2);

	// ****************************************************************
	// Link state machine
	// ****************************************************************
	always_comb begin
		next_r = r;
		next_r.scl_s1 = i_scl;
		next_r.scl_s2 = r.scl_s1;
		next_r.scl_s3 = r.scl_s2;
		next_r.sda_s1 = i_sda;
		next_r.sda_s2 = r.sda_s1;
		next_r.sda_s3 = r.sda_s2;
		next_r.wp_s1 = i_write_protect_pin;
		next_r.wp_s2 = r.wp_s1;
		next_r.cs_s1 = i_chip_select_bits;
		next_r.cs_s2 = r.cs_s1;
		next_r.soft_lock_s1 = soft_write_lock_bit;
		next_r.soft_lock_s2 = r.soft_lock_s1;
		next_r.lck_s1 = locked;
		next_r.lck_s2 = r.lck_s1;
		next_r.done_s1 = done_tgl;
		next_r.done_s2 = r.done_s1;
		if (start_seen) begin
			// A start always restarts the byte framing
			next_r.st = L_DEV;
			next_r.bitcnt = 4'h0;
			next_r.drive = 1'b0;
			// Buffer is frozen while the engine still reads it
			if (!pending) begin
				next_r.vld = '0;
				next_r.nbytes = '0;
			end
		end else if (stop_seen) begin
			// Any other stop only returns to idle
			next_r.st = L_IDLE;
			next_r.drive = 1'b0;
			// Stop right after an acknowledged data byte slot only
			if (r.st == L_DATA && r.bitcnt == 4'h1 && r.nbytes != '0 && !pending) begin
				if ((r.op != eewc_pkg::OP_SOFT_LOCK && r.op != eewc_pkg::OP_LOCK) || r.nbytes == 5'h01) begin
					next_r.req_tgl = ~r.req_tgl;
				end
			end
		end else begin
			unique case (r.st)
				L_IDLE, L_SKIP: begin
					// Silent until the next start or stop
					next_r.drive = 1'b0;
				end
				L_DEV: begin
					// Shift in at each synchronised rising edge
					if (scl_rise) begin
						next_r.sh = byte_in;
						next_r.bitcnt = r.bitcnt + 4'h1;
					end
					if (last_bit) begin
						// No answer at all while programming
						next_r.want_ack = addr_ack;
						next_r.addr[8] = byte_in[eewc_pkg::DEV_A8_BIT];
						next_r.op = (byte_in[7:4] == eewc_pkg::TYPE_MAIN) ? eewc_pkg::OP_MAIN
							: eewc_pkg::OP_NONE;
						if (!addr_ack) begin
							next_r.after = L_SKIP;
						end else if (byte_in[eewc_pkg::DEV_RW_BIT]) begin
							next_r.after = L_SKIP;
						end else begin
							next_r.after = L_WORD;
						end
						next_r.st = L_ACK;
						next_r.bitcnt = 4'h0;
					end
				end
				L_WORD: begin
					// Shift in at each synchronised rising edge
					if (scl_rise) begin
						next_r.sh = byte_in;
						next_r.bitcnt = r.bitcnt + 4'h1;
					end
					if (last_bit) begin
						next_r.addr[7:0] = byte_in;
						// Main array kind is final; the auxiliary type splits here
						if (r.op != eewc_pkg::OP_MAIN) begin
							unique case (byte_in[eewc_pkg::SEL_LSB +: 2])
								eewc_pkg::SEL_IDENT: next_r.op = eewc_pkg::OP_IDENT;
								eewc_pkg::SEL_LOCK: next_r.op = eewc_pkg::OP_LOCK;
								eewc_pkg::SEL_SOFT_LOCK: next_r.op = eewc_pkg::OP_SOFT_LOCK;
								eewc_pkg::SEL_UID: next_r.op = eewc_pkg::OP_NONE;
							endcase
						end
						next_r.want_ack = 1'b1;
						next_r.after = L_DATA;
						next_r.st = L_ACK;
						next_r.bitcnt = 4'h0;
					end
				end
				L_DATA: begin
					// Shift in at each synchronised rising edge
					if (scl_rise) begin
						next_r.sh = byte_in;
						next_r.bitcnt = r.bitcnt + 4'h1;
					end
					if (last_bit) begin
						// Protected or locked bytes, other than soft lock ones, are refused and never stored
						next_r.want_ack = data_ack;
						if (data_ack) begin
							next_r.pbuf[idx] = byte_in;
							next_r.vld[idx] = 1'b1;
							// Count saturates at one page; extra bytes only overwrite
							if (r.nbytes != 5'h10) begin
								next_r.nbytes = r.nbytes + 5'h01;
							end
							if (r.op == eewc_pkg::OP_MAIN || r.op == eewc_pkg::OP_IDENT) begin
								next_r.addr[3:0] = idx + 4'h1;
							end
						end
						next_r.after = L_DATA;
						next_r.st = L_ACK;
						next_r.bitcnt = 4'h0;
					end
				end
				L_ACK: begin
					// Drive on the first fall, release on the second
					// Moving only after a fall keeps the line steady while high
					if (scl_fall) begin
						if (r.bitcnt == 4'h0) begin
							next_r.drive = r.want_ack;
							next_r.bitcnt = 4'h1;
						end else begin
							next_r.drive = 1'b0;
							next_r.st = r.after;
							next_r.bitcnt = 4'h0;
						end
					end
				end
				default: next_r.st = L_IDLE;
			endcase
		end
	end

	// ****************************************************************
	// Link registers
	// ****************************************************************
	// Reset only loads constants; straps are sampled afterwards
	// Edge taps start at the idle high level, so no false edge follows
	always_ff @(posedge i_link_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			r <= '{scl_s1: 1'b1, scl_s2: 1'b1, scl_s3: 1'b1,
				sda_s1: 1'b1, sda_s2: 1'b1, sda_s3: 1'b1,
				wp_s1: 1'b0, wp_s2: 1'b0,
				cs_s1: 2'h0, cs_s2: 2'h0,
				soft_lock_s1: eewc_pkg::SOFT_LOCK_RESET, soft_lock_s2: eewc_pkg::SOFT_LOCK_RESET,
				lck_s1: eewc_pkg::LOCK_RESET, lck_s2: eewc_pkg::LOCK_RESET,
				done_s1: 1'b0, done_s2: 1'b0,
				st: L_IDLE, after: L_IDLE,
				bitcnt: 4'h0, sh: 8'h00,
				want_ack: 1'b0, drive: 1'b0,
				addr: '0, op: eewc_pkg::OP_NONE,
				pbuf: '0, vld: '0,
				nbytes: '0,
				req_tgl: 1'b0};
		end else begin
			r <= next_r;
		end
	end

	// ****************************************************************
	// Commit engine on the system clock
	// ****************************************************************
	// Buffer fields are held stable by the toggle handshake
	eewc_commit #(
		.WRITE_CYCLES(WRITE_CYCLES)
	) u_commit (
		.i_sys_clk(i_sys_clk),
		.i_rst_b(i_rst_b),
		.i_req_tgl(r.req_tgl),
		.i_op(r.op),
		.i_base(r.addr),
		.i_data(r.pbuf),
		.i_vld(r.vld),
		.i_count(r.nbytes),
		.o_done_tgl(done_tgl),
		.o_busy(busy),
		.o_soft_write_lock_bit(soft_write_lock_bit),
		.o_locked(locked)
	);

	// Open-drain data: only ever pulls low
	assign o_sda = 1'b0;
	assign o_sda_oe_b = ~r.drive;
	// Status outputs straight from the engine's flip-flops
	assign o_busy = busy;
	assign o_soft_write_lock_bit = soft_write_lock_bit;
	assign o_ident_locked = locked;
endmodule

/* File: verif/eewc_checker.sv */
/* Checker for eewc_top: acknowledge timing on the wire and write-cycle status.
 * Assumes it is bound to eewc_top and sees only that module's ports. */
`timescale 1ns/1ps
module eewc_checker #(
	parameter int WRITE_CYCLES = eewc_pkg::WRITE_CYCLES
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic i_link_clk,
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic o_sda,
	input wire logic o_sda_oe_b,
	input wire logic i_write_protect_pin,
	input wire logic [1:0] i_chip_select_bits,
	input wire logic o_busy,
	input wire logic o_soft_write_lock_bit,
	input wire logic o_ident_locked
);
	int busy_cnt;

	// ****************************************************************
	// Helper logic
	// ****************************************************************
	// Length of the current busy stretch, too long for a repetition
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			busy_cnt <= 0;
		end else if (o_busy) begin
			busy_cnt <= busy_cnt + 1;
		end else begin
			busy_cnt <= 0;
		end
	end

	// ****************************************************************
	// Properties
	// ****************************************************************
	// Pull held low until the serial clock falls again
	sequence s_ack_held;
		!o_sda_oe_b throughout (##[1:40] !i_scl);
	endsequence
	property p_ack_hold;
		@(posedge i_link_clk) disable iff (!i_rst_b) $rose(i_scl) && !o_sda_oe_b |-> s_ack_held;
	endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("ack released while clock high");
	property p_pull_low;
		@(posedge i_link_clk) disable iff (!i_rst_b) !o_sda_oe_b |-> o_sda == 1'b0;
	endproperty
	a_pull_low: assert property (p_pull_low) else $error("enabled pin not pulling low");
	// Device may only move the data line while the clock is low
	property p_oe_edge;
		@(posedge i_link_clk) disable iff (!i_rst_b) $changed(o_sda_oe_b) |-> !i_scl;
	endproperty
	a_oe_edge: assert property (p_oe_edge) else $error("data line moved while clock high");
	property p_busy_quiet;
		@(posedge i_sys_clk) disable iff (!i_rst_b) o_busy |-> o_sda_oe_b;
	endproperty
	a_busy_quiet: assert property (p_busy_quiet) else $error("answer during write cycle");
	property p_busy_len;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
			$fell(o_busy) |-> busy_cnt >= WRITE_CYCLES - 1 && busy_cnt <= WRITE_CYCLES + 1;
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("write cycle length wrong");
	// Programming only follows a stop, so the bus is idle high
	property p_busy_idle;
		@(posedge i_sys_clk) disable iff (!i_rst_b) $rose(o_busy) |-> i_scl && i_sda;
	endproperty
	a_busy_idle: assert property (p_busy_idle) else $error("write cycle without stop");
	property p_soft_lock_when;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
			$changed(o_soft_write_lock_bit) |-> (o_busy || $past(o_busy)) or (##[1:3] o_busy);
	endproperty
	a_soft_lock_when: assert property (p_soft_lock_when) else $error("soft lock moved outside a write");
	property p_lock_keep;
		@(posedge i_sys_clk) disable iff (!i_rst_b) $past(o_ident_locked) |-> o_ident_locked;
	endproperty
	a_lock_keep: assert property (p_lock_keep) else $error("ident lock undone");
	property p_lock_when;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
			$rose(o_ident_locked) |-> (o_busy || $past(o_busy)) or (##[1:3] o_busy);
	endproperty
	a_lock_when: assert property (p_lock_when) else $error("ident lock outside a write");
endmodule

bind eewc_top eewc_checker #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
	.i_link_clk(i_link_clk), .i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe_b(o_sda_oe_b),
	.i_write_protect_pin(i_write_protect_pin), .i_chip_select_bits(i_chip_select_bits), .o_busy(o_busy),
	.o_soft_write_lock_bit(o_soft_write_lock_bit), .o_ident_locked(o_ident_locked));

/* File: verif/eewc_ctrl_model.sv */
/* Two-wire bus controller model: start, stop and byte transfers, MSB first.
 * Assumes an outside pull-up resolves its open-drain data output. */
`timescale 1ns/1ps
module eewc_ctrl_model (
	input wire logic i_sys_clk,
	input wire logic i_sda_line,
	output logic o_scl,
	output logic o_sda
);
	// Idle bus: both lines released high
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	// One phase of the serial clock, moved just after a system edge
	task automatic q();
		repeat (2) @(posedge i_sys_clk);
		#1;
	endtask
	// Data falls while clock high
	task automatic start();
		o_sda = 1'b1;
		q();
		o_scl = 1'b1;
		q();
		o_sda = 1'b0;
		q();
		o_scl = 1'b0;
		q();
	endtask
	// Data settles a phase after the fall, so no false start or stop
	task automatic put_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			o_sda = b[i];
			q();
			o_scl = 1'b1;
			q();
			o_scl = 1'b0;
			q();
		end
		o_sda = 1'b1;
		q();
		o_scl = 1'b1;
		q();
		ack = !i_sda_line;
		o_scl = 1'b0;
		q();
	endtask
	// Stop in the slot after the acknowledge
	task automatic stop();
		o_sda = 1'b0;
		q();
		o_scl = 1'b1;
		q();
		o_sda = 1'b1;
		q();
	endtask
endmodule

/* File: verif/eewc_top_test.sv */
/* Self-checking bench for eewc_top, driven through the controller model.
 * Assumes the write cycle length is shortened by parameter. */
`timescale 1ns/1ps
module eewc_top_test;
	localparam int WC = 400;
	localparam logic [7:0] AM = 8'ha8;
	localparam logic [7:0] AX = 8'hb8;
	logic sys_clk = 1'b0;
	logic link_clk = 1'b0;
	logic rst_b = 1'b0;
	logic wp = 1'b0;
	logic scl;
	logic sda_drv;
	logic sda;
	logic sda_out;
	logic sda_oe_b;
	logic busy;
	logic soft_lock;
	logic [1:0] cs = 2'h2;
	logic locked;
	int fails = 0;
	int check_count = 0;

	// Open-drain wire with pull-up
	assign sda = sda_drv & (sda_oe_b | sda_out);
	// Clocks, link clock free running and out of phase
	initial forever #12.5 sys_clk = ~sys_clk;
	initial begin
		#1.7;
		forever #3 link_clk = ~link_clk;
	end

	eewc_top #(.WRITE_CYCLES(WC)) dut (.i_sys_clk(sys_clk), .i_rst_b(rst_b), .i_link_clk(link_clk),
		.i_scl(scl), .i_sda(sda), .o_sda(sda_out), .o_sda_oe_b(sda_oe_b), .i_write_protect_pin(wp),
		.i_chip_select_bits(cs), .o_busy(busy), .o_soft_write_lock_bit(soft_lock), .o_ident_locked(locked));
	eewc_ctrl_model ctl (.i_sys_clk(sys_clk), .i_sda_line(sda), .o_scl(scl), .o_sda(sda_drv));

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic got, input logic exp, input string m);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask
	task automatic put(input logic [7:0] b, input logic e, input string m);
		logic a;
		ctl.put_byte(b, a);
		chk(a, e, m);
	endtask
	// Address byte alone, then stop
	task automatic rd(input logic [7:0] b, input logic e);
		ctl.start();
		put(b, e, "address answer");
		ctl.stop();
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] w, input logic [7:0] d, input int n, input logic e);
		ctl.start();
		put(a, 1'b1, "address ack");
		put(w, 1'b1, "word ack");
		for (int i = 0; i < n; i++) put(d + 8'(i), e, "data answer");
		ctl.stop();
	endtask
	// Mode 0 idle, 1 busy, 2 either; first poll must match, later bounded
	task automatic poll(input int m);
		logic a;
		a = 1'b0;
		repeat (20) @(posedge sys_clk);
		#1;
		if (m < 2) chk(busy, m[0], "busy level");
		for (int k = 0; k < 40 && !a; k++) begin
			ctl.start();
			ctl.put_byte(AM, a);
			ctl.stop();
			if (k == 0 && m < 2) chk(a, !m[0], "first poll answer");
		end
		chk(a, 1'b1, "poll timeout");
		if (!a) stop_test();
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		repeat (5) @(posedge sys_clk);
		#1;
		rst_b = 1'b1;
		repeat (4) @(posedge sys_clk);
		wr(AM, 8'h35, 8'h5a, 1, 1'b1);
		poll(1);
		wr(AM, 8'h10, 8'h00, 0, 1'b1);
		poll(0);
		wr(AM | 8'h02, 8'h4e, 8'h00, 18, 1'b1);
		poll(1);
		rd(8'ha0, 1'b0);
		rd(8'hc8, 1'b0);
		// Straps moved: the answer must follow them
		cs = 2'h0;
		rd(8'ha0, 1'b1);
		rd(AM, 1'b0);
		cs = 2'h2;
		rd(AM | 8'h01, 1'b1);
		wp = 1'b1;
		wr(AM, 8'h20, 8'h33, 1, 1'b0);
		poll(0);
		wr(AX, 8'h05, 8'h44, 1, 1'b0);
		poll(0);
		wr(AX, 8'hc0, 8'h01, 1, 1'b1);
		poll(2);
		chk(soft_lock, 1'b1, "soft lock set");
		rd(AX | 8'h01, 1'b1);
		wp = 1'b0;
		wr(AM, 8'h20, 8'h33, 2, 1'b0);
		poll(0);
		wr(AX, 8'hc0, 8'h00, 2, 1'b1);
		poll(2);
		chk(soft_lock, 1'b1, "soft lock kept");
		wr(AX, 8'hfe, 8'hfe, 1, 1'b1);
		poll(2);
		chk(soft_lock, 1'b0, "soft lock clear");
		wr(AX, 8'h3d, 8'h11, 3, 1'b1);
		poll(1);
		wr(AX, 8'h40, 8'h02, 1, 1'b1);
		poll(2);
		chk(locked, 1'b1, "ident locked");
		wr(AX, 8'h7f, 8'hff, 1, 1'b0);
		poll(0);
		wr(AX, 8'h02, 8'h11, 1, 1'b0);
		poll(0);
		stop_test();
	end
endmodule
